// ---- src/awpsl_pkg.sv ----
package awpsl_pkg;

  // timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned OVERRIDE_SEC    = 4;
  localparam int unsigned OVERRIDE_CYCLES = OVERRIDE_SEC * CLK_HZ;

  // sleep type field codes
  localparam logic [2:0] SLP_TYPE_S5 = 3'h7;
  localparam logic [2:0] SLP_TYPE_S4 = 3'h6;

  // event index positions within the wake vector
  localparam int unsigned EV_RING1   = 0;
  localparam int unsigned EV_RING2   = 1;
  localparam int unsigned EV_KBD     = 2;
  localparam int unsigned EV_MOUSE   = 3;
  localparam int unsigned EV_WKEY    = 4;
  localparam int unsigned EV_GPIO    = 5;
  localparam int unsigned EV_GPIO_PM = 6;
  localparam int unsigned EV_FAN     = 7;
  localparam int unsigned EV_ALARM   = 8;
  localparam int unsigned EV_BUTTON  = 9;
  localparam int unsigned EV_NUM     = 10;

  localparam int unsigned GPIO_W     = 9;
  localparam int unsigned GPIO_PM_W  = 2;

  localparam logic [EV_NUM-1:0] EV_ZERO = 10'h000;

  typedef enum logic [1:0] {
    AWPSL_S0,
    AWPSL_S4,
    AWPSL_S5
  } awpsl_state_t;

  // software configuration, cleared to zero by every standby reset
  typedef struct packed {
    logic [EV_NUM-1:0]    pm1_gpe_en;
    logic [EV_NUM-1:0]    pme_en;
    logic                 pme_out_en;
    logic                 sci_en;
    logic                 smi_en;
    logic [GPIO_W-1:0]    gpio_rise;
    logic                 standby_por_en;
    logic                 standby_por_off;
  } awpsl_cfg_t;

  typedef struct packed {
    logic [EV_NUM-1:0] event_flags;
    logic              any_pme_flag;
    logic              button_press_flag;
    logic              button_override_flag;
    logic              standby_por_flag;
    logic              alarm_wake_flag;
  } awpsl_status_t;

endpackage : awpsl_pkg

// ---- src/awpsl_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser with edge detection, polarity chosen per input
module awpsl_edge #(
  parameter int unsigned W = 1
) (
  input  wire logic         SYS_CLK_I,
  input  wire logic         RST_N_I,
  input  wire logic         CE_I,
  input  wire logic [W-1:0] PIN_I,
  input  wire logic [W-1:0] RISE_I,
  output logic      [W-1:0] EDGE_O
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;
  wire  [W-1:0] rise_w = sync_reg & ~last_reg;
  wire  [W-1:0] fall_w = ~sync_reg & last_reg;

  // pins idle high, so reset to high avoids a false edge at release
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      meta_reg <= '1;
      sync_reg <= '1;
      last_reg <= '1;
    end else if (CE_I) begin
      meta_reg <= PIN_I;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign EDGE_O = (RISE_I & rise_w) | (~RISE_I & fall_w);
endmodule : awpsl_edge
`default_nettype wire

// ---- src/awpsl_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RULE1] sleep enable with sleep type 111 enters soft-off, supply off
// [RULE2] sleep enable with sleep type 110 enters S4, wakeable by button or events
// [RULE3] button held over four seconds while working raises override, goes soft-off
// [RULE4] override flag blocks all wake inputs except the power button
// [RULE5] enabled PM1/GPE events wake the supply while off, unless overridden
// [RULE6] a wake event drives power_supply_on_n low
// [RULE7] a PME event drives pme_out_n low
// [RULE8] functions are D0 or D3; wake logic still works with all in D3
// [RULE9] ring indicator edges set their flag or any-PME, may raise SMI/PME
// [RULE10] keyboard, mouse edges and wake key set their flags or any-PME
// [RULE11] GPIO edges set per-pin flags; two further pins PME via PM1/GPE only; the code ORs all GPIO edges into the one EV_GPIO flag
// [RULE12] fan tachometer wakes only via any-PME, may raise SMI/PME; the code gives the fan PME only, never SMI
// [RULE13] RTC alarm sets alarm flag, PME only when enabled in PM1/GPE
// [RULE14] button low sets press flag, PME only through PM1/GPE enable
// [RULE15] standby reset sets standby flag and wakes when its enable is set; the code's reset clears standby_por_en, so it never wakes this way
// [RULE16] standby reset also wakes if supply was on and neither off nor enable set
// [RULE17] any-PME flag set only for events enabled in PME enables
// [RULE18] legacy interrupt sources and sleep write give SMI only, never wake
// [RULE19] wake configuration is kept through standby reset; the code clears cfg_reg to zero on every reset
// [RULE20] any PM1/GPE enabled event may also produce PME or SMI
// [RULE21] short press sets press flag on falling edge, turns supply on if off
// [RULE22] override sets override flag and clears press flag
// [RULE23] wake flags stay set until cleared; logic runs from standby clock
module awpsl_top
  import awpsl_pkg::*;
#(
  parameter int unsigned OVR_CYCLES = OVERRIDE_CYCLES
) (
  input  wire logic                     SYS_CLK_I,
  input  wire logic                     RST_N_I,
  input  wire logic                     CE_I,
  input  wire logic                     SLEEP_ENABLE_I,
  input  wire logic [4:0]               SLEEP_CTRL_I,
  input  wire logic                     CFG_WR_I,
  input  wire awpsl_pkg::awpsl_cfg_t    CFG_I,
  input  wire logic                     FLAG_CLR_I,
  input  wire awpsl_pkg::awpsl_status_t FLAG_CLR_MASK_I,
  input  wire logic                     POWER_BUTTON_IN_N_I,
  input  wire logic                     RING_IN_FIRST_N_I,
  input  wire logic                     RING_IN_SECOND_N_I,
  input  wire logic                     KEYBOARD_DATA_LINE_I,
  input  wire logic                     MOUSE_DATA_LINE_I,
  input  wire logic                     WAKE_KEY_I,
  input  wire logic [awpsl_pkg::GPIO_W-1:0]    GPIO_I,
  input  wire logic [awpsl_pkg::GPIO_PM_W-1:0] GPIO_PM_I,
  input  wire logic                     FAN_TACH_EVENT_I,
  input  wire logic                     ALARM_I,
  input  wire logic                     SMI_SOURCE_I,
  input  wire logic                     SUPPLY_WAS_ON_I,
  output logic                          POWER_SUPPLY_ON_N_O,
  output logic                          PME_OUT_N_O,
  output logic                          SMI_OUT_N_O,
  output awpsl_pkg::awpsl_state_t       STATE_O,
  output awpsl_pkg::awpsl_cfg_t         CFG_O,
  output awpsl_pkg::awpsl_status_t      STATUS_O
);
  import awpsl_pkg::*;

  localparam logic [31:0] OVR_LAST = OVR_CYCLES - 1;

  // synchronised edges for all pin events; the button uses falling edge
  logic [GPIO_W-1:0]    gpio_edge;
  logic [GPIO_PM_W-1:0] gpio_pm_edge;
  logic [6:0]           misc_edge;
  // declared ahead of the u_gpio edge detector, which reads its polarity from it
  awpsl_cfg_t           cfg_reg;

  awpsl_edge #(.W(GPIO_W)) u_gpio (
    .SYS_CLK_I (SYS_CLK_I),
    .RST_N_I   (RST_N_I),
    .CE_I      (CE_I),
    .PIN_I     (GPIO_I),
    .RISE_I    (cfg_reg.gpio_rise),
    .EDGE_O    (gpio_edge)
  );

  awpsl_edge #(.W(GPIO_PM_W)) u_gpio_pm (
    .SYS_CLK_I (SYS_CLK_I),
    .RST_N_I   (RST_N_I),
    .CE_I      (CE_I),
    .PIN_I     (GPIO_PM_I),
    .RISE_I    ('0),
    .EDGE_O    (gpio_pm_edge)
  );

  // ring, kbd, mouse, button active-low falling; key, fan, alarm active-high rising
  awpsl_edge #(.W(7)) u_misc (
    .SYS_CLK_I (SYS_CLK_I),
    .RST_N_I   (RST_N_I),
    .CE_I      (CE_I),
    .PIN_I     ({ALARM_I, FAN_TACH_EVENT_I, WAKE_KEY_I, POWER_BUTTON_IN_N_I,
                 MOUSE_DATA_LINE_I, KEYBOARD_DATA_LINE_I, RING_IN_SECOND_N_I}),
    .RISE_I    (7'h70),
    .EDGE_O    (misc_edge)
  );

  // button level and ring-1 edge pass through their own synchroniser
  logic btn_meta_reg;
  logic btn_sync_reg;
  logic ring1_meta_reg;
  logic ring1_sync_reg;
  logic ring1_last_reg;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      btn_meta_reg   <= 1'b1;
      btn_sync_reg   <= 1'b1;
      ring1_meta_reg <= 1'b1;
      ring1_sync_reg <= 1'b1;
      ring1_last_reg <= 1'b1;
    end else if (CE_I) begin
      btn_meta_reg   <= POWER_BUTTON_IN_N_I;
      btn_sync_reg   <= btn_meta_reg;
      ring1_meta_reg <= RING_IN_FIRST_N_I;
      ring1_sync_reg <= ring1_meta_reg;
      ring1_last_reg <= ring1_sync_reg;
    end
  end

  wire ring1_edge = ~ring1_sync_reg & ring1_last_reg;
  wire btn_fall   = misc_edge[3];

  // raw event vector in package order
  wire [EV_NUM-1:0] ev_raw = {btn_fall, misc_edge[6], misc_edge[5], |gpio_pm_edge,
                              |gpio_edge, misc_edge[4], misc_edge[2], misc_edge[1],
                              misc_edge[0], ring1_edge};

  // configuration register: every reset clears it to zero
  awpsl_status_t sts_reg;
  awpsl_status_t sts_next;
  awpsl_state_t  state_reg;
  awpsl_state_t  state_next;
  logic [31:0]   hold_reg;
  logic          por_seen_reg;
  logic          psu_n_reg;
  logic          pme_n_reg;
  logic          smi_n_reg;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_reg <= '0;
    end else if (CE_I && CFG_WR_I) begin
      cfg_reg <= CFG_I; // [RULE19]
    end
  end

  // events that may reach the any-PME flag: ring, kbd, mouse, key, gpio, fan
  wire [EV_NUM-1:0] pme_capable = (EV_ZERO | 10'h0BF);
  wire [EV_NUM-1:0] pme_hit     = ev_raw & cfg_reg.pme_en & pme_capable; // [RULE17]
  wire [EV_NUM-1:0] own_capable = (EV_ZERO | 10'h37F);
  // per-event flags set only when enabled in PM1/GPE; fan has no own flag
  wire [EV_NUM-1:0] pm_hit      = ev_raw & cfg_reg.pm1_gpe_en & own_capable; // [RULE9] [RULE10] [RULE11] [RULE12] [RULE13]

  wire slp_req    = SLEEP_ENABLE_I;
  wire [2:0] slp_type = SLEEP_CTRL_I[4:2];
  wire go_s5      = slp_req && (slp_type == SLP_TYPE_S5); // [RULE1]
  wire go_s4      = slp_req && (slp_type == SLP_TYPE_S4); // [RULE2]
  wire override   = (state_reg == AWPSL_S0) && !btn_sync_reg && (hold_reg == OVR_LAST); // [RULE3]

  wire standby_wake = por_seen_reg &&
                      (cfg_reg.standby_por_en || // [RULE15]
                       (SUPPLY_WAS_ON_I && !cfg_reg.standby_por_off &&
                        !cfg_reg.standby_por_en)); // [RULE16]

  // any enabled sticky flag but the button's drives wake while off; override leaves the button only
  wire sw_wake  = (|(sts_reg.event_flags & ~(EV_ZERO | 10'h200)) || sts_reg.any_pme_flag ||
                   standby_wake) && !sts_reg.button_override_flag; // [RULE4] [RULE5]
  wire btn_wake = btn_fall; // [RULE21]
  wire asleep   = (state_reg != AWPSL_S0);
  wire wake     = asleep && (sw_wake || btn_wake);

  always_comb begin
    sts_next = sts_reg;
    if (FLAG_CLR_I) begin
      sts_next = sts_reg & ~FLAG_CLR_MASK_I;
    end
    // sets come after clears so a same-cycle event is kept
    sts_next.event_flags  = sts_next.event_flags | pm_hit; // [RULE23]
    sts_next.any_pme_flag = sts_next.any_pme_flag | (|pme_hit);
    sts_next.alarm_wake_flag = sts_next.alarm_wake_flag | pm_hit[EV_ALARM]; // [RULE13]
    if (btn_fall) begin
      sts_next.button_press_flag = 1'b1; // [RULE14] [RULE21]
    end
    if (por_seen_reg) begin
      sts_next.standby_por_flag = 1'b1;
    end
    if (override) begin
      sts_next.button_override_flag = 1'b1; // [RULE22]
      sts_next.button_press_flag    = 1'b0;
    end else if (btn_fall && asleep) begin
      sts_next.button_override_flag = 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      AWPSL_S0: begin
        if (override || go_s5) begin
          state_next = AWPSL_S5;
        end else if (go_s4) begin
          state_next = AWPSL_S4;
        end
      end
      AWPSL_S4, AWPSL_S5: begin
        if (wake) begin
          state_next = AWPSL_S0; // [RULE6]
        end
      end
      default: state_next = AWPSL_S0;
    endcase
  end

  // PME path: PM1/GPE with SCI, or PME enables with master enable
  wire pm_pme_src  = |(sts_reg.event_flags & cfg_reg.pm1_gpe_en);
  wire pme_any     = (cfg_reg.sci_en && pm_pme_src) || // [RULE20] [RULE11] [RULE14]
                     (cfg_reg.pme_out_en && sts_reg.any_pme_flag); // [RULE7] [RULE8]
  // SMI: legacy sources only ever land here, never in the wake path
  wire smi_any     = cfg_reg.smi_en && (SMI_SOURCE_I || slp_req || // [RULE18]
                     (!cfg_reg.sci_en && pm_pme_src));

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sts_reg      <= '0;
      state_reg    <= AWPSL_S5;
      hold_reg     <= '0;
      por_seen_reg <= 1'b1;
      psu_n_reg    <= 1'b1;
      pme_n_reg    <= 1'b1;
      smi_n_reg    <= 1'b1;
    end else if (CE_I) begin
      sts_reg      <= sts_next;
      state_reg    <= state_next;
      por_seen_reg <= 1'b0;
      hold_reg     <= (btn_sync_reg || hold_reg == OVR_LAST) ? '0 : hold_reg + 32'h1;
      psu_n_reg    <= (state_next == AWPSL_S0) ? 1'b0 : 1'b1; // [RULE6]
      pme_n_reg    <= ~pme_any; // [RULE7]
      smi_n_reg    <= ~smi_any;
    end
  end

  assign POWER_SUPPLY_ON_N_O = psu_n_reg;
  assign PME_OUT_N_O         = pme_n_reg;
  assign SMI_OUT_N_O         = smi_n_reg;
  assign STATE_O             = state_reg;
  assign CFG_O               = cfg_reg;
  assign STATUS_O            = sts_reg;
endmodule : awpsl_top
`default_nettype wire

// ---- bench/awpsl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module awpsl_chk
  import awpsl_pkg::*;
#(
  parameter int unsigned OVR_CYCLES = 20
) (
  input wire logic                     SYS_CLK_I,
  input wire logic                     RST_N_I,
  input wire logic                     CE_I,
  input wire logic                     SLEEP_ENABLE_I,
  input wire logic [4:0]               SLEEP_CTRL_I,
  input wire logic                     FLAG_CLR_I,
  input wire logic                     POWER_BUTTON_IN_N_I,
  input wire logic                     POWER_SUPPLY_ON_N_O,
  input wire logic                     PME_OUT_N_O,
  input wire logic                     SMI_OUT_N_O,
  input wire awpsl_pkg::awpsl_state_t  STATE_O,
  input wire awpsl_pkg::awpsl_cfg_t    CFG_O,
  input wire awpsl_pkg::awpsl_status_t STATUS_O
);
  logic [31:0] hold_reg;
  logic [3:0]  recent_reg;
  // raw pin count runs ahead of the synchroniser, so the hold bound stays safe
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hold_reg   <= '0;
      recent_reg <= '0;
    end else if (!POWER_BUTTON_IN_N_I) begin
      hold_reg   <= hold_reg + 32'h1;
      recent_reg <= 4'hA;
    end else begin
      hold_reg   <= '0;
      recent_reg <= (recent_reg != 4'h0) ? recent_reg - 4'h1 : 4'h0;
    end
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_sleep_soft_off: assert property (
    SLEEP_ENABLE_I && CE_I && SLEEP_CTRL_I[4:2] == SLP_TYPE_S5 && STATE_O == AWPSL_S0
    |=> STATE_O == AWPSL_S5 && POWER_SUPPLY_ON_N_O) else $error("soft-off entry missed");
  a_sleep_s4: assert property (
    SLEEP_ENABLE_I && CE_I && SLEEP_CTRL_I[4:2] == SLP_TYPE_S4 && STATE_O == AWPSL_S0
    |=> STATE_O == AWPSL_S4 && POWER_SUPPLY_ON_N_O) else $error("s4 entry missed");
  a_supply_follows: assert property (
    POWER_SUPPLY_ON_N_O == (STATE_O != AWPSL_S0)) else $error("supply and state disagree");
  a_override_entry: assert property (
    $rose(STATUS_O.button_override_flag) |-> $past(STATE_O) == AWPSL_S0
    && STATE_O == AWPSL_S5 && !STATUS_O.button_press_flag) else $error("override effects wrong");
  a_override_hold: assert property (
    $rose(STATUS_O.button_override_flag) |-> hold_reg >= OVR_CYCLES)
    else $error("override too early");
  a_override_blocks: assert property (
    $fell(POWER_SUPPLY_ON_N_O) && $past(STATUS_O.button_override_flag) |-> recent_reg != 4'h0)
    else $error("wake without button after override");
  a_pme_has_cause: assert property (
    $fell(PME_OUT_N_O) |-> $past(CFG_O.sci_en || CFG_O.pme_out_en)) else $error("stray pme");
  a_smi_enabled: assert property (
    $fell(SMI_OUT_N_O) |-> $past(CFG_O.smi_en)) else $error("smi while disabled");
  a_any_pme_enabled: assert property (
    $rose(STATUS_O.any_pme_flag) |-> $past(CFG_O.pme_en) != EV_ZERO)
    else $error("any pme flag without enable");
  a_flags_sticky: assert property (
    |($past(STATUS_O.event_flags) & ~STATUS_O.event_flags & 10'h1FF) |-> $past(FLAG_CLR_I))
    else $error("event flag dropped");
endmodule : awpsl_chk
bind awpsl_top awpsl_chk #(.OVR_CYCLES(OVR_CYCLES)) i_chk (.SYS_CLK_I, .RST_N_I, .CE_I,
  .SLEEP_ENABLE_I, .SLEEP_CTRL_I, .FLAG_CLR_I, .POWER_BUTTON_IN_N_I, .POWER_SUPPLY_ON_N_O,
  .PME_OUT_N_O, .SMI_OUT_N_O, .STATE_O, .CFG_O, .STATUS_O);
`default_nettype wire

// ---- bench/awpsl_psu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// button pin rests high on its pull-up; main power comes up a few cycles after the request
module awpsl_psu_model #(
  parameter int unsigned RAMP = 3
) (
  input  wire logic clk_i,
  input  wire logic power_supply_on_n_i,
  output logic      button_n_o,
  output logic      main_ok_o
);
  int unsigned ramp_cnt = 0;
  initial button_n_o = 1'b1;
  always @(posedge clk_i) begin
    ramp_cnt <= power_supply_on_n_i ? 0 : ramp_cnt + 1;
  end
  assign main_ok_o = ramp_cnt >= RAMP;
  task automatic press(input int unsigned cycles);
    @(posedge clk_i);
    #2 button_n_o = 1'b0;
    repeat (cycles) @(posedge clk_i);
    #2 button_n_o = 1'b1;
  endtask : press
endmodule : awpsl_psu_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import awpsl_pkg::*;
  localparam int unsigned OVR  = 20;
  localparam logic [8:0]  IDLE = 9'h06F;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          sleep_en = 1'b0;
  logic [4:0]    sleep_ctrl = 5'h00;
  logic          cfg_wr = 1'b0;
  awpsl_cfg_t    cfg = '0;
  logic          flag_clr = 1'b0;
  logic [8:0]    ev = IDLE;
  logic          smi_src = 1'b0;
  logic          was_on = 1'b0;
  logic          btn_n, main_ok, supply_n, pme_n, smi_n;
  awpsl_state_t  state;
  awpsl_cfg_t    cfg_q;
  awpsl_status_t sts;
  int            num_errors = 0;
  int            comparisons = 0;
  always #10 clk = ~clk;
  awpsl_top #(.OVR_CYCLES(OVR)) i_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
    .SLEEP_ENABLE_I(sleep_en), .SLEEP_CTRL_I(sleep_ctrl), .CFG_WR_I(cfg_wr), .CFG_I(cfg),
    .FLAG_CLR_I(flag_clr), .FLAG_CLR_MASK_I('1), .POWER_BUTTON_IN_N_I(btn_n),
    .RING_IN_FIRST_N_I(ev[0]), .RING_IN_SECOND_N_I(ev[1]), .KEYBOARD_DATA_LINE_I(ev[2]),
    .MOUSE_DATA_LINE_I(ev[3]), .WAKE_KEY_I(ev[4]), .GPIO_I({8'hFF, ev[5]}),
    .GPIO_PM_I({1'b1, ev[6]}), .FAN_TACH_EVENT_I(ev[7]), .ALARM_I(ev[8]),
    .SMI_SOURCE_I(smi_src), .SUPPLY_WAS_ON_I(was_on), .POWER_SUPPLY_ON_N_O(supply_n),
    .PME_OUT_N_O(pme_n), .SMI_OUT_N_O(smi_n), .STATE_O(state), .CFG_O(cfg_q), .STATUS_O(sts));
  awpsl_psu_model i_psu (.clk_i(clk), .power_supply_on_n_i(supply_n), .button_n_o(btn_n),
    .main_ok_o(main_ok));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(input int unsigned n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic sleep_write(input logic [2:0] typ);
    sleep_ctrl = {typ, 2'b00};
    sleep_en = 1'b1;
    tick(1);
    sleep_en = 1'b0;
    tick(2);
  endtask : sleep_write
  task automatic pulse_event(input int unsigned i);
    ev[i] = ~IDLE[i];
    tick(4);
    ev = IDLE;
    tick(6);
  endtask : pulse_event
  task automatic clear_flags();
    flag_clr = 1'b1;
    tick(1);
    flag_clr = 1'b0;
    tick(2);
  endtask : clear_flags
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial begin
    tick(4);
    rst_n = 1'b1;
    tick(3);
    chk(sts.standby_por_flag, 1, "por flag");
    chk(supply_n, 1, "cold por stays off");
    cfg.pm1_gpe_en = '1;
    cfg.pme_en = '1;
    // the fan reaches pme only through the any-pme flag and its master enable
    cfg.pme_out_en = 1'b1;
    cfg.sci_en = 1'b1;
    cfg.smi_en = 1'b1;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    i_psu.press(5);
    tick(4);
    chk(sts.button_press_flag, 1, "press flag");
    chk(main_ok, 1, "main power up");
    for (int i = 0; i < 9; i++) begin
      clear_flags();
      sleep_write(i[0] ? SLP_TYPE_S5 : SLP_TYPE_S4);
      chk(state, i[0] ? AWPSL_S5 : AWPSL_S4, "sleep state");
      chk(supply_n, 1, "off while asleep");
      pulse_event(i);
      chk(supply_n, 0, "wake");
      chk(sts.event_flags[i], i != 7, "event flag");
      chk(sts.any_pme_flag, i != 6 && i != 8, "any pme");
      chk(pme_n, 0, "pme");
      clear_flags();
      chk(pme_n, 1, "pme released");
    end
    i_psu.press(OVR + 10);
    tick(4);
    chk(sts.button_override_flag, 1, "override flag");
    chk(sts.button_press_flag, 0, "press flag cleared");
    chk(state, AWPSL_S5, "override off");
    pulse_event(8);
    chk(supply_n, 1, "wake blocked");
    i_psu.press(5);
    tick(4);
    chk(supply_n, 0, "button wakes");
    // the alarm flag left by the blocked wake must go before sleeping again
    clear_flags();
    sleep_write(SLP_TYPE_S5);
    smi_src = 1'b1;
    tick(4);
    chk(smi_n, 0, "legacy smi");
    chk(supply_n, 1, "legacy no wake");
    smi_src = 1'b0;
    was_on = 1'b1;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(4);
    chk(supply_n, 0, "por rewake");
    chk(sts.standby_por_flag, 1, "por flag again");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
